//--- hdl/sdibw_addr_map.sv
// Maps an internal address onto address pins 19..5 for a 32-bit data bus
// Assumes geometry code and phase come from the controller
`timescale 1ns/1ps
module sdibw_addr_map (
    input wire logic [31:0] addr,
    input wire logic [1:0] geo,
    input wire logic four_bank,
    input wire logic col_phase,
    input wire logic auto_pre,
    output logic [19:5] pins
);
    import sdibw_pkg::*;

    function automatic logic [4:0] hi_bit(input logic [1:0] g, input logic [1:0] pos,
        input logic col);
        logic [4:0] b;
        b = 5'h00;
        case (g)
            2'h0: b = (pos == 2'h0) ? 5'h18 : (pos == 2'h1) ? 5'h19 : (pos == 2'h2) ? 5'h18 : 5'h15;
            2'h1: b = (pos == 2'h0) ? 5'h19 : (pos == 2'h1) ? 5'h1A : (pos == 2'h2) ? 5'h19
                : (col ? 5'h18 : 5'h15);
            2'h2: b = (pos == 2'h0) ? 5'h17 : (pos == 2'h1) ? 5'h18 : (pos == 2'h2) ? 5'h16 : 5'h15;
            default: b = (pos == 2'h0) ? 5'h18 : (pos == 2'h1) ? 5'h19 : (pos == 2'h2) ? 5'h16
                : 5'h15;
        endcase
        return b;
    endfunction : hi_bit

    logic [4:0] col_hi14;
    logic [4:0] col_hi13;

    always_comb
    begin
        col_hi14 = geo[1] ? 5'h18 : 5'h17;
        col_hi13 = geo[1] ? 5'h17 : 5'h16;
        pins[19] = addr[hi_bit(geo, 2'h0, col_phase)];
        pins[18] = four_bank ? addr[hi_bit(geo, 2'h1, col_phase)]
            : addr[hi_bit(geo, 2'h1, col_phase)];
        pins[17] = addr[hi_bit(geo, 2'h2, col_phase)];
        pins[16] = addr[hi_bit(geo, 2'h3, col_phase)];
        if (col_phase)
        begin
            pins[15] = auto_pre;
            pins[14] = addr[col_hi14];
            pins[13] = addr[col_hi13];
            pins[12:5] = addr[9:2];
        end
        else
        begin
            pins[15:5] = addr[20:10];
        end
    end
endmodule : sdibw_addr_map

//--- hdl/sdibw_consts.svh
// Offsets, fields, reset values and timing counts of the init and broadcast block
// Assumes a 100 MHz clock and byte addresses on AXI4-Lite
// How it works
// - 32-bit bus: row pins 15..5 get bits 20..10, column pins 12..5 bits 9..2
// - pins 19 and 18 take the same geometry address bits for two banks and for four banks
// - column pin 15 is high with auto-precharge, low without
// - command register writes produce precharge-all or mode-register-set cycles
// - one timing register serves every channel
// - each issued refresh lowers the refresh count field until zero
// - pending refresh wins over every other request
// - channel enable clear disables; enable with master makes a broadcast master
// - enable with slave makes a broadcast slave; neither means normal
// - a write to a master channel also writes every enabled slave
// - a slave targeted directly behaves as an ordinary channel
// - master-and-slave channel broadcasts and also receives other masters' writes
// - the master channel's check-code mode drives all written channels
`ifndef SDIBW_CONSTS_SVH
`define SDIBW_CONSTS_SVH
`define SDIBW_OFF_CHAN0 8'h00
`define SDIBW_OFF_CHAN3 8'h0C
`define SDIBW_OFF_TIMING 8'h10
`define SDIBW_OFF_CMD 8'h14
`define SDIBW_OFF_STATUS 8'h18
`define SDIBW_CC_CE 0
`define SDIBW_CC_ME 1
`define SDIBW_CC_SE 2
`define SDIBW_CC_ECC_LO 4
`define SDIBW_CC_GEO_LO 8
`define SDIBW_CC_FOURBANK 10
`define SDIBW_CC_MASK 32'h0000_0777
`define SDIBW_TM_RC_LO 16
`define SDIBW_TM_GAP_LO 24
`define SDIBW_TM_MASK 32'h0FFF_FFFF
`define SDIBW_CLK_NS 10
`define SDIBW_TGAP_NS 20
`define SDIBW_GAP_CYC ((`SDIBW_TGAP_NS + `SDIBW_CLK_NS - 1) / `SDIBW_CLK_NS)
`define SDIBW_RP_RESET 16'h0618
`define SDIBW_TM_RESET {4'h0, 4'(`SDIBW_GAP_CYC), 8'h00, `SDIBW_RP_RESET}
`define SDIBW_CMD_MODE_LO 4
`endif

//--- hdl/sdibw_ctrl.sv
// Init command, refresh counting and broadcast write sequencer with AXI4-Lite registers
// Assumes one access request at a time from the on-chip bus and shared command pins
`timescale 1ns/1ps
`include "sdibw_consts.svh"
module sdibw_ctrl (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [1:0] req_chan,
    input wire logic [31:0] req_addr,
    input wire logic req_auto_pre,
    output logic req_done,
    output logic req_err,
    output logic [3:0] sd_cs_n,
    output logic sd_ras_n,
    output logic sd_cas_n,
    output logic sd_we_n,
    output logic [19:5] sd_addr,
    output logic [2:0] sd_ecc_mode
);
    import sdibw_pkg::*;

    logic [31:0] chan_ctrl [4];
    logic [31:0] timing;
    logic cmd_pend;
    sdibw_op_t cmd_op;
    logic [14:0] cmd_mode;
    logic aw_held, w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [31:0] next_chan_ctrl [4];
    logic [31:0] next_timing;
    logic next_cmd_pend;
    sdibw_op_t next_cmd_op;
    logic [14:0] next_cmd_mode;
    logic next_aw_held, next_w_held, next_bvalid, next_rvalid;
    logic [7:0] next_aw_addr;
    logic [31:0] next_w_data, next_rdata;
    logic [3:0] next_w_strb;
    logic [1:0] next_bresp, next_rresp;
    logic do_write;

    sdibw_state_t state, next_state, ret, next_ret;
    logic [3:0] gap, next_gap;
    logic lat_write, next_lat_write;
    logic [1:0] lat_chan, next_lat_chan;
    logic [31:0] lat_addr, next_lat_addr;
    logic lat_auto_pre, next_lat_auto_pre;
    logic [3:0] next_cs_n;
    logic next_ras_n, next_cas_n, next_we_n;
    logic [19:5] next_sd_addr;
    logic [2:0] next_ecc;
    logic next_done, next_err;
    logic ref_pend, ref_ack;
    logic col_phase;
    logic [19:5] map_pins;
    logic [3:0] ce_vec, me_vec, se_vec, write_sel;
    logic [31:0] tgt_cc;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
        input logic [3:0] strb, input logic [31:0] mask);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                m[i*8 +: 8] = data[i*8 +: 8];
        end
        return m & mask;
    endfunction : merge

    sdibw_refresh sdibw_refresh_inst (
        .clock(clock),
        .rst_n(rst_n),
        .period(timing[15:0]),
        .ack(ref_ack),
        .pending(ref_pend)
    );

    sdibw_addr_map sdibw_addr_map_inst (
        .addr(lat_addr),
        .geo(tgt_cc[`SDIBW_CC_GEO_LO +: 2]),
        .four_bank(tgt_cc[`SDIBW_CC_FOURBANK]),
        .col_phase(col_phase),
        .auto_pre(lat_auto_pre),
        .pins(map_pins)
    );

    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            ce_vec[i] = chan_ctrl[i][`SDIBW_CC_CE];
            me_vec[i] = chan_ctrl[i][`SDIBW_CC_ME] & ce_vec[i];
            se_vec[i] = chan_ctrl[i][`SDIBW_CC_SE] & ce_vec[i];
        end
        tgt_cc = chan_ctrl[lat_chan];
        col_phase = (state == ST_RW);
        write_sel = 4'h0;
        write_sel[lat_chan] = 1'b1;
        if (lat_write && me_vec[lat_chan])
            write_sel = write_sel | se_vec;
    end

    // Register bus
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    always_comb
    begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid && !s_axi_bready;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid && !s_axi_rready;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        next_chan_ctrl = chan_ctrl;
        next_timing = timing;
        next_cmd_pend = cmd_pend;
        next_cmd_op = cmd_op;
        next_cmd_mode = cmd_mode;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (state == ST_REF && timing[`SDIBW_TM_RC_LO +: 8] != 8'h00)
            next_timing[`SDIBW_TM_RC_LO +: 8] = timing[`SDIBW_TM_RC_LO +: 8] - 8'h01;
        // A precharge after an access must not swallow a pending mode set
        if (state == ST_MRS || (state == ST_PRE && cmd_op == OP_PRE_ALL))
            next_cmd_pend = 1'b0;
        do_write = next_aw_held && next_w_held && !s_axi_bvalid;
        if (do_write)
        begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = 2'b00;
            if (next_aw_addr <= `SDIBW_OFF_CHAN3 && next_aw_addr[1:0] == 2'b00)
                next_chan_ctrl[next_aw_addr[3:2]] = merge(chan_ctrl[next_aw_addr[3:2]],
                    next_w_data, next_w_strb, `SDIBW_CC_MASK);
            else if (next_aw_addr == `SDIBW_OFF_TIMING)
                next_timing = merge(timing, next_w_data, next_w_strb, `SDIBW_TM_MASK);
            else if (next_aw_addr == `SDIBW_OFF_CMD)
            begin
                if (next_w_data[1:0] == OP_PRE_ALL || next_w_data[1:0] == OP_MODE_SET)
                begin
                    next_cmd_pend = 1'b1;
                    next_cmd_op = sdibw_op_t'(next_w_data[1:0]);
                    next_cmd_mode = next_w_data[`SDIBW_CMD_MODE_LO +: 15];
                end
            end
            else
                next_bresp = 2'b10;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_rvalid = 1'b1;
            next_rresp = 2'b00;
            next_rdata = 32'h0000_0000;
            if (s_axi_araddr <= `SDIBW_OFF_CHAN3 && s_axi_araddr[1:0] == 2'b00)
                next_rdata = chan_ctrl[s_axi_araddr[3:2]];
            else if (s_axi_araddr == `SDIBW_OFF_TIMING)
                next_rdata = timing;
            else if (s_axi_araddr == `SDIBW_OFF_CMD)
                next_rdata = {13'h0000, cmd_mode, cmd_pend, 1'b0, cmd_op};
            else if (s_axi_araddr == `SDIBW_OFF_STATUS)
                next_rdata = {27'h0000000, ref_pend, cmd_pend, state};
            else
                next_rresp = 2'b10;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
            for (int i = 0; i < 4; i++)
                chan_ctrl[i] <= 32'h0000_0000;
            timing <= `SDIBW_TM_RESET;
            cmd_pend <= 1'b0;
            cmd_op <= OP_NONE;
            cmd_mode <= 15'h0000;
        end
        else
        begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
            chan_ctrl <= next_chan_ctrl;
            timing <= next_timing;
            cmd_pend <= next_cmd_pend;
            cmd_op <= next_cmd_op;
            cmd_mode <= next_cmd_mode;
        end
    end

    // Memory sequencer
    assign req_ready = (state == ST_IDLE) && !ref_pend && !cmd_pend;
    assign ref_ack = (state == ST_REF);

    always_comb
    begin
        next_state = state;
        next_ret = ret;
        next_gap = gap;
        next_lat_write = lat_write;
        next_lat_chan = lat_chan;
        next_lat_addr = lat_addr;
        next_lat_auto_pre = lat_auto_pre;
        next_cs_n = 4'hF;
        next_ras_n = 1'b1;
        next_cas_n = 1'b1;
        next_we_n = 1'b1;
        next_sd_addr = sd_addr;
        next_ecc = sd_ecc_mode;
        next_done = 1'b0;
        next_err = 1'b0;
        case (state)
            ST_IDLE:
            begin
                if (ref_pend)
                    next_state = ST_REF;
                else if (cmd_pend)
                    next_state = (cmd_op == OP_MODE_SET) ? ST_MRS : ST_PRE;
                else if (req_valid)
                begin
                    next_lat_write = req_write;
                    next_lat_chan = req_chan;
                    next_lat_addr = req_addr;
                    next_lat_auto_pre = req_auto_pre;
                    if (ce_vec[req_chan])
                        next_state = ST_ACT;
                    else
                        next_err = 1'b1;
                end
            end
            ST_REF:
            begin
                next_cs_n = ~ce_vec;
                next_ras_n = 1'b0;
                next_cas_n = 1'b0;
                next_ret = ST_IDLE;
                next_state = ST_WAIT;
            end
            ST_ACT:
            begin
                next_cs_n = ~write_sel;
                next_ras_n = 1'b0;
                next_sd_addr = map_pins;
                next_ret = ST_RW;
                next_state = ST_WAIT;
            end
            ST_RW:
            begin
                next_cs_n = ~write_sel;
                next_cas_n = 1'b0;
                next_we_n = ~lat_write;
                next_sd_addr = map_pins;
                next_ecc = chan_ctrl[lat_chan][`SDIBW_CC_ECC_LO +: 3];
                next_done = 1'b1;
                next_ret = lat_auto_pre ? ST_IDLE : ST_PRE;
                next_lat_auto_pre = 1'b1;
                next_state = ST_WAIT;
            end
            ST_PRE:
            begin
                next_cs_n = ~ce_vec;
                next_ras_n = 1'b0;
                next_we_n = 1'b0;
                next_sd_addr = 15'h0000;
                next_sd_addr[15] = 1'b1;
                next_ret = ST_IDLE;
                next_state = ST_WAIT;
            end
            ST_MRS:
            begin
                next_cs_n = ~ce_vec;
                next_ras_n = 1'b0;
                next_cas_n = 1'b0;
                next_we_n = 1'b0;
                next_sd_addr = cmd_mode;
                next_ret = ST_IDLE;
                next_state = ST_WAIT;
            end
            ST_WAIT:
            begin
                if (gap >= timing[`SDIBW_TM_GAP_LO +: 4])
                begin
                    next_gap = 4'h0;
                    next_state = ret;
                end
                else
                    next_gap = gap + 4'h1;
            end
            default:
                next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            state <= ST_IDLE;
            ret <= ST_IDLE;
            gap <= 4'h0;
            lat_write <= 1'b0;
            lat_chan <= 2'h0;
            lat_addr <= 32'h0000_0000;
            lat_auto_pre <= 1'b0;
            sd_cs_n <= 4'hF;
            sd_ras_n <= 1'b1;
            sd_cas_n <= 1'b1;
            sd_we_n <= 1'b1;
            sd_addr <= 15'h0000;
            sd_ecc_mode <= 3'h0;
            req_done <= 1'b0;
            req_err <= 1'b0;
        end
        else
        begin
            state <= next_state;
            ret <= next_ret;
            gap <= next_gap;
            lat_write <= next_lat_write;
            lat_chan <= next_lat_chan;
            lat_addr <= next_lat_addr;
            lat_auto_pre <= next_lat_auto_pre;
            sd_cs_n <= next_cs_n;
            sd_ras_n <= next_ras_n;
            sd_cas_n <= next_cas_n;
            sd_we_n <= next_we_n;
            sd_addr <= next_sd_addr;
            sd_ecc_mode <= next_ecc;
            req_done <= next_done;
            req_err <= next_err;
        end
    end

    a_refresh_wins: assert property (@(posedge clock) disable iff (!rst_n)
        (state == ST_IDLE && ref_pend) |=> (state == ST_REF) ##1 (!sd_ras_n && !sd_cas_n))
        else $error("refresh not granted first");
    a_count_down: assert property (@(posedge clock) disable iff (!rst_n)
        (state == ST_REF && timing[23:16] != 8'h00 && !do_write)
        |=> timing[23:16] == $past(timing[23:16]) - 8'h01)
        else $error("refresh count not lowered");
    a_count_hold: assert property (@(posedge clock) disable iff (!rst_n)
        (timing[23:16] == 8'h00 && !do_write) |=> timing[23:16] == 8'h00)
        else $error("refresh count left zero");
    a_cmd_issue: assert property (@(posedge clock) disable iff (!rst_n)
        (state == ST_IDLE && cmd_pend && !ref_pend) |=> (state == ST_PRE || state == ST_MRS)
        ##1 (!sd_ras_n && !sd_we_n))
        else $error("init command not issued");
    a_disabled_quiet: assert property (@(posedge clock) disable iff (!rst_n)
        (state == ST_RW) |=> ((~sd_cs_n & ~$past(ce_vec)) == 4'h0))
        else $error("disabled channel selected");
    a_broadcast_all: assert property (@(posedge clock) disable iff (!rst_n)
        (state == ST_RW && lat_write && me_vec[lat_chan])
        |=> ((~sd_cs_n & $past(se_vec)) == $past(se_vec)) && !sd_we_n)
        else $error("slave missed broadcast write");
    a_slave_normal: assert property (@(posedge clock) disable iff (!rst_n)
        (state == ST_RW && !lat_write) |=> (~sd_cs_n == (4'h1 << $past(lat_chan))))
        else $error("read not on target channel only");
    a_ap_pin: assert property (@(posedge clock) disable iff (!rst_n)
        (state == ST_RW) |=> (sd_addr[15] == $past(lat_auto_pre)) && !sd_cas_n)
        else $error("auto precharge pin wrong");
    a_row_map: assert property (@(posedge clock) disable iff (!rst_n)
        (state == ST_ACT) |=> (sd_addr[15:5] == $past(lat_addr[20:10])))
        else $error("row address mapping wrong");
    a_ecc_master: assert property (@(posedge clock) disable iff (!rst_n)
        (state == ST_RW) |=> (sd_ecc_mode == $past(chan_ctrl[lat_chan][6:4])))
        else $error("check mode not from master");
endmodule : sdibw_ctrl

//--- hdl/sdibw_pkg.sv
// Types of the init and broadcast block
// Assumes the constants header is compiled alongside
package sdibw_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_REF = 3'b001,
        ST_ACT = 3'b010,
        ST_RW = 3'b011,
        ST_PRE = 3'b100,
        ST_MRS = 3'b101,
        ST_WAIT = 3'b110
    } sdibw_state_t;
    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_PRE_ALL = 2'b01,
        OP_MODE_SET = 2'b10
    } sdibw_op_t;
endpackage : sdibw_pkg

//--- hdl/sdibw_refresh.sv
// Refresh period timer raising a pending request until acknowledged
// Assumes the period is given in clock cycles
`timescale 1ns/1ps
module sdibw_refresh (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [15:0] period,
    input wire logic ack,
    output logic pending
);
    import sdibw_pkg::*;

    logic [15:0] count;
    logic [15:0] next_count;
    logic next_pending;
    logic tick;

    always_comb
    begin
        tick = (period != 16'h0000) && (count >= period - 16'h0001);
        next_count = tick ? 16'h0000 : count + 16'h0001;
        next_pending = tick | (pending & ~ack);
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            count <= 16'h0000;
            pending <= 1'b0;
        end
        else
        begin
            count <= next_count;
            pending <= next_pending;
        end
    end
endmodule : sdibw_refresh

//--- testbench/sdibw_sdram_model.sv
// Memory-side monitor: records each selected command and counts refreshes that select channel 0
// Assumes active-low command pins driven by the controller on its clock
`timescale 1ns/1ps
module sdibw_sdram_model (
    input wire logic clock,
    input wire logic [3:0] sd_cs_n,
    input wire logic sd_ras_n,
    input wire logic sd_cas_n,
    input wire logic sd_we_n,
    input wire logic [19:5] sd_addr,
    output int ref_seen,
    output logic [2:0] last_cmd,
    output logic [19:5] last_addr
);
    initial
    begin
        ref_seen = 0;
        last_cmd = 3'h7;
        last_addr = 15'h0000;
        forever
        begin
            @(posedge clock);
            if (!sd_cs_n[0] && !sd_ras_n && !sd_cas_n && sd_we_n)
                ref_seen <= ref_seen + 1;
            if (sd_cs_n != 4'hF)
            begin
                last_cmd <= {sd_ras_n, sd_cas_n, sd_we_n};
                last_addr <= sd_addr;
            end
        end
    end
endmodule : sdibw_sdram_model

//--- testbench/sdram_init_and_broadcast_write_tb.sv
// Self-checking bench for the init and broadcast write controller
// Assumes the design files and the memory monitor are compiled first
`timescale 1ns/1ps
module sdram_init_and_broadcast_write_tb;
    logic clock = 1'h0;
    logic rst_n = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, req_addr = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF, sd_cs_n;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, req_valid = 1'h0;
    logic req_write = 1'h0, req_auto_pre = 1'h0;
    logic [1:0] req_chan = 2'h0, s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic req_ready, req_done, req_err, sd_ras_n, sd_cas_n, sd_we_n;
    logic [19:5] sd_addr, last_addr;
    logic [2:0] sd_ecc_mode, last_cmd;
    int fail_count = 0, n_compared = 0, ref_seen;
    always #5 clock = ~clock;
    sdibw_ctrl sdibw_ctrl_inst (.clock, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .req_valid, .req_ready, .req_write, .req_chan, .req_addr, .req_auto_pre,
        .req_done, .req_err, .sd_cs_n, .sd_ras_n, .sd_cas_n, .sd_we_n, .sd_addr,
        .sd_ecc_mode);
    sdibw_sdram_model sdibw_sdram_model_inst (.clock, .sd_cs_n, .sd_ras_n, .sd_cas_n,
        .sd_we_n, .sd_addr, .ref_seen, .last_cmd, .last_addr);
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic tmo(input int n);
        if (n <= 0)
        begin
            fail_count++;
            $display("[ERR] wait expected answer seen timeout");
            summarize();
        end
    endtask : tmo
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (n = 100; n > 0; n--)
        begin
            @(posedge clock);
            if (s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid)
            begin
                chk("bresp", 2'h0, s_axi_bresp);
                break;
            end
        end
        tmo(n);
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (n = 100; n > 0; n--)
        begin
            @(posedge clock);
            if (s_axi_arready)
                s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid)
                break;
        end
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        tmo(n);
    endtask : axi_rd
    task automatic wait_cmd(input logic [2:0] rcw);
        int n;
        for (n = 50; n > 0 && last_cmd !== rcw; n--)
            @(posedge clock);
        tmo(n);
    endtask : wait_cmd
    task automatic access(input logic w, input logic [1:0] ch, input logic [31:0] a,
        input logic pre, input logic [3:0] cs, input logic err);
        int n;
        req_write <= w;
        req_chan <= ch;
        req_addr <= a;
        req_auto_pre <= pre;
        req_valid <= 1'h1;
        for (n = 100; n > 0; n--)
        begin
            @(posedge clock);
            if (req_ready)
                break;
        end
        req_valid <= 1'h0;
        tmo(n);
        for (n = 30; n > 0; n--)
        begin
            @(posedge clock);
            if (!sd_ras_n)
                chk("row pins", a[20:10], sd_addr[15:5]);
            if (req_err || !sd_cas_n)
                break;
        end
        tmo(n);
        chk("req_err", err, req_err);
        chk("req_done", !err, req_done);
        if (!err)
        begin
            chk("col pins", {pre, a[9:2]}, {sd_addr[15], sd_addr[12:5]});
            chk("cs_n", cs, sd_cs_n);
        end
    endtask : access
    task automatic scen_init;
        axi_rd(8'h10);
        chk("timing reset", 32'h0200_0618, rd);
        axi_rd(8'h1C);
        chk("unmapped resp", 2'h2, rs);
        axi_wr(8'h00, 32'h0000_0053);
        axi_wr(8'h04, 32'h0000_0005);
        axi_wr(8'h08, 32'h0000_0007);
        axi_wr(8'h0C, 32'h0000_0006);
        axi_wr(8'h10, 32'h0200_0000);
        axi_wr(8'h14, 32'h0000_0001);
        wait_cmd(3'h2);
        chk("pre-all pin15", 1'h1, last_addr[15]);
        axi_wr(8'h14, 32'h0000_2302);
        wait_cmd(3'h0);
        chk("mode pins", 15'h0230, last_addr);
        axi_rd(8'h14);
        chk("cmd read", 32'h0000_2302, rd);
    endtask : scen_init
    task automatic scen_bcast;
        access(1'h1, 2'h0, 32'h0012_3458, 1'h1, 4'h8, 1'h0);
        chk("check mode", 3'h5, sd_ecc_mode);
        access(1'h1, 2'h2, 32'h0004_0ABC, 1'h0, 4'h9, 1'h0);
        chk("check mode", 3'h0, sd_ecc_mode);
        access(1'h0, 2'h1, 32'h0001_5554, 1'h1, 4'hD, 1'h0);
        access(1'h1, 2'h3, 32'h0000_0100, 1'h0, 4'hF, 1'h1);
        for (int i = 0; i < 32; i++)
            access(1'h1, 2'h0, 32'h0000_1000 + i * 4, 1'h1, 4'h8, 1'h0);
    endtask : scen_bcast
    task automatic scen_refresh;
        int n, r0;
        r0 = ref_seen;
        axi_wr(8'h10, 32'h0203_0010);
        for (n = 40; n > 0; n--)
        begin
            axi_rd(8'h10);
            if (rd[23:16] === 8'h00)
                break;
        end
        tmo(n);
        chk("refreshes", 32'h3, ref_seen - r0);
        repeat (40) @(posedge clock);
        axi_rd(8'h10);
        chk("count holds", 8'h00, rd[23:16]);
        chk("refresh runs", 1'h1, (ref_seen - r0) > 3);
        axi_wr(8'h10, 32'h0200_0618);
    endtask : scen_refresh
    initial
    begin
        repeat (12) @(posedge clock);
        rst_n <= 1'h1;
        @(posedge clock);
        scen_init();
        scen_bcast();
        scen_refresh();
        summarize();
    end
endmodule : sdram_init_and_broadcast_write_tb
